// ===== common/atr_pkg.sv
// constants for the analog test register set
package atr_pkg;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 32;
    // register indices as printed; byte address is four times the index, cut to the 16-bit bus width
    localparam logic [15:0] IDX_DAC_ONE      = 16'h6329;
    localparam logic [15:0] IDX_DAC_TWO      = 16'h632A;
    localparam logic [15:0] IDX_ADC_OBSERVE  = 16'h632B;
    localparam logic [15:0] IDX_FIELD_DET    = 16'h632F;
    localparam logic [15:0] IDX_ROUTE        = 16'h6330;
    // field layout
    localparam int unsigned DAC_W            = 6;
    localparam int unsigned SAMPLE_W         = 4;
    localparam int unsigned SEL_W            = 4;
    localparam int unsigned PD_BIT           = 4;
    localparam int unsigned I_LSB            = 4;
    localparam int unsigned SEL_TWO_LSB      = 0;
    localparam int unsigned SEL_ONE_LSB      = 4;
    // pin select codes
    localparam logic [3:0]  SEL_TRISTATE     = 4'h0;
    localparam logic [3:0]  SEL_DAC_REG      = 4'h1;
    // reset values
    localparam logic [5:0]  DAC_RST          = 6'h00;
    localparam logic        PD_RST           = 1'b0;
    localparam logic [7:0]  ROUTE_RST        = 8'h00;
    // answer for unmapped addresses
    localparam logic [31:0] UNMAPPED_DATA    = 32'h0000_0000;
endpackage

// ===== rtl/atr_regs.sv
// analog test register set: dac test values, adc observation, level detector power-down
module atr_regs
    import atr_pkg::*;
(
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_nrst,
    input  wire logic [atr_pkg::ADDR_W-1:0] i_avs_address,
    input  wire logic                    i_avs_read,
    input  wire logic                    i_avs_write,
    input  wire logic [atr_pkg::DATA_W-1:0] i_avs_writedata,
    input  wire logic [3:0]              i_avs_byteenable,
    output logic [atr_pkg::DATA_W-1:0]   o_avs_readdata,
    output logic                         o_avs_waitrequest,
    output logic [1:0]                   o_avs_response,
    input  wire logic [atr_pkg::SAMPLE_W-1:0] i_adc_i_sample,
    input  wire logic [atr_pkg::SAMPLE_W-1:0] i_adc_q_sample,
    output logic [atr_pkg::DAC_W-1:0]    o_first_dac_code,
    output logic [atr_pkg::DAC_W-1:0]    o_second_dac_code,
    output logic                         o_first_test_output_pin_oe_n,
    output logic                         o_second_test_output_pin_oe_n,
    output logic                         o_field_detector_powerdown
);
    import atr_pkg::*;

    // byte address of a register index
    function automatic logic [ADDR_W-1:0] reg_addr(input logic [15:0] idx);
        reg_addr = ADDR_W'({idx, 2'b00});
    endfunction

    // pin enable from a select code: only the dac code drives the pin
    function automatic logic pin_oe_n(input logic [SEL_W-1:0] sel);
        pin_oe_n = (sel == SEL_DAC_REG) ? 1'b0 : 1'b1;
    endfunction

    logic [DAC_W-1:0]    dac_one_r;
    logic [DAC_W-1:0]    dac_two_r;
    logic                pd_r;
    logic [7:0]          route_r;
    logic                ack_r;
    logic [DATA_W-1:0]   rdata_r;
    logic [DATA_W-1:0]   rdata_nxt;
    logic [SAMPLE_W-1:0] i_s1_r;
    logic [SAMPLE_W-1:0] i_s2_r;
    logic [SAMPLE_W-1:0] i_s3_r;
    logic [SAMPLE_W-1:0] i_stable_r;
    logic [SAMPLE_W-1:0] q_s1_r;
    logic [SAMPLE_W-1:0] q_s2_r;
    logic [SAMPLE_W-1:0] q_s3_r;
    logic [SAMPLE_W-1:0] q_stable_r;
    logic                wreq_r;
    logic [1:0]          resp_r;
    logic                hit_dac_one;
    logic                hit_dac_two;
    logic                hit_adc;
    logic                hit_fdet;
    logic                hit_route;
    logic [SEL_W-1:0]    sel_one;
    logic [SEL_W-1:0]    sel_two;
    logic                oe1_n_r;
    logic                oe2_n_r;
    logic                wr_go;
    logic                rd_go;

    // in-phase sample comes from the analog side; three stages, accept when stages two and three agree
    // a word caught mid-change is held back rather than shown torn, at the cost of a few cycles of lag
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            i_s1_r     <= '0;
            i_s2_r     <= '0;
            i_s3_r     <= '0;
            i_stable_r <= '0;
        end else begin
            i_s1_r <= i_adc_i_sample;
            i_s2_r <= i_s1_r;
            i_s3_r <= i_s2_r;
            if (i_s2_r == i_s3_r) begin
                i_stable_r <= i_s3_r;
            end
        end
    end

    // quadrature sample, same three-stage filter as the in-phase one
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            q_s1_r     <= '0;
            q_s2_r     <= '0;
            q_s3_r     <= '0;
            q_stable_r <= '0;
        end else begin
            q_s1_r <= i_adc_q_sample;
            q_s2_r <= q_s1_r;
            q_s3_r <= q_s2_r;
            if (q_s2_r == q_s3_r) begin
                q_stable_r <= q_s3_r;
            end
        end
    end

    // address decode, shared by the write path and the read mux
    assign hit_dac_one = (i_avs_address == reg_addr(IDX_DAC_ONE));
    assign hit_dac_two = (i_avs_address == reg_addr(IDX_DAC_TWO));
    assign hit_adc     = (i_avs_address == reg_addr(IDX_ADC_OBSERVE));
    assign hit_fdet    = (i_avs_address == reg_addr(IDX_FIELD_DET));
    assign hit_route   = (i_avs_address == reg_addr(IDX_ROUTE));

    // one wait cycle per access keeps read data registered; a request is taken while ack_r is low
    assign wr_go = i_avs_write && !ack_r;
    assign rd_go = i_avs_read && !ack_r;

    // ack_r marks the single cycle in which the answer stands
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (i_avs_read || i_avs_write) && !ack_r;
        end
    end

    // waitrequest has its own flop so the pin has no gate behind it; it is always the inverse of ack_r
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wreq_r <= 1'b1;
        end else begin
            wreq_r <= !((i_avs_read || i_avs_write) && !ack_r);
        end
    end

    // every access completes; unmapped ones read zero instead of raising an error response
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            resp_r <= 2'h0;
        end else begin
            resp_r <= 2'h0;
        end
    end

    // register writes; only byte lane 0 carries register data
    // a write with lane 0 masked, or to an unmapped address, leaves every register alone
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            dac_one_r <= DAC_RST;
            dac_two_r <= DAC_RST;
            pd_r      <= PD_RST;
            route_r   <= ROUTE_RST;
        end else if (wr_go && i_avs_byteenable[0]) begin
            // bits 7:6 of a dac write are dropped, so they can never read back as one
            if (hit_dac_one) begin
                dac_one_r <= i_avs_writedata[DAC_W-1:0];
            end
            if (hit_dac_two) begin
                dac_two_r <= i_avs_writedata[DAC_W-1:0];
            end
            if (hit_fdet) begin
                // reserved bits are expected zero and are not stored
                pd_r <= i_avs_writedata[PD_BIT];
            end
            if (hit_route) begin
                route_r <= i_avs_writedata[7:0];
            end
        end
    end

    // read mux; samples are the synchronised live values at the access
    always_comb begin
        rdata_nxt = UNMAPPED_DATA;
        if (hit_dac_one) begin
            rdata_nxt = DATA_W'(dac_one_r);
        end else if (hit_dac_two) begin
            rdata_nxt = DATA_W'(dac_two_r);
        end else if (hit_adc) begin
            rdata_nxt = DATA_W'({i_stable_r, q_stable_r});
        end else if (hit_fdet) begin
            rdata_nxt = DATA_W'({pd_r, 4'h0});
        end else if (hit_route) begin
            rdata_nxt = DATA_W'(route_r);
        end
    end

    // read data is loaded when the request is taken and stands until the next read
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_r <= '0;
        end else if (rd_go) begin
            rdata_r <= rdata_nxt;
        end
    end

    // select fields of the routing register
    assign sel_one = route_r[SEL_ONE_LSB +: SEL_W];
    assign sel_two = route_r[SEL_TWO_LSB +: SEL_W];

    // pin routing: code zero floats the pin, code one drives the dac value
    // other codes name sources this block does not have, so they float the pin as well
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            oe1_n_r <= 1'b1;
            oe2_n_r <= 1'b1;
        end else begin
            oe1_n_r <= pin_oe_n(sel_one);
            oe2_n_r <= pin_oe_n(sel_two);
        end
    end

    // every output comes straight from a flop
    assign o_avs_readdata                = rdata_r;
    assign o_avs_waitrequest             = wreq_r;
    assign o_avs_response                = resp_r;
    assign o_first_dac_code              = dac_one_r;
    assign o_second_dac_code             = dac_two_r;
    assign o_first_test_output_pin_oe_n  = oe1_n_r;
    assign o_second_test_output_pin_oe_n = oe2_n_r;
    assign o_field_detector_powerdown    = pd_r;
endmodule

// ===== testbench/atr_regs_sva.sv
// checker for bus timing and register effects of the analog test register set
module atr_regs_chk
    import atr_pkg::*;
(
    input wire logic i_sys_clk, i_nrst, i_avs_read, i_avs_write, o_avs_waitrequest, o_field_detector_powerdown,
    input wire logic o_first_test_output_pin_oe_n, o_second_test_output_pin_oe_n,
    input wire logic [atr_pkg::ADDR_W-1:0] i_avs_address,
    input wire logic [atr_pkg::DATA_W-1:0] i_avs_writedata, o_avs_readdata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [atr_pkg::DAC_W-1:0] o_first_dac_code, o_second_dac_code
);
    // byte addresses are the index shifted by two, cut to the bus width
    localparam logic [15:0] A1 = {IDX_DAC_ONE[13:0], 2'b00};
    localparam logic [15:0] A2 = {IDX_DAC_TWO[13:0], 2'b00};
    localparam logic [15:0] AP = {IDX_FIELD_DET[13:0], 2'b00};
    localparam logic [15:0] AR = {IDX_ROUTE[13:0], 2'b00};
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    // a request taken: strobe present while the slave still holds off
    sequence s_wr(logic [15:0] a); i_avs_write && o_avs_waitrequest && i_avs_address == a && i_avs_byteenable[0]; endsequence
    sequence s_rd(logic [15:0] a); i_avs_read && o_avs_waitrequest && i_avs_address == a; endsequence
    a_wait_one: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("waitrequest not low one cycle after request");
    a_wait_pulse: assert property (!o_avs_waitrequest |=> o_avs_waitrequest) else $error("waitrequest low too long");
    a_dac1_wr: assert property (s_wr(A1) |=> o_first_dac_code == $past(i_avs_writedata[5:0]))
        else $error("first dac code not written");
    a_dac2_wr: assert property (s_wr(A2) |=> o_second_dac_code == $past(i_avs_writedata[5:0]))
        else $error("second dac code not written");
    a_dac1_hold: assert property ($changed(o_first_dac_code) |-> $past(i_avs_write && i_avs_address == A1))
        else $error("first dac code changed without write");
    a_pd_wr: assert property (s_wr(AP) |=> o_field_detector_powerdown == $past(i_avs_writedata[4]))
        else $error("power-down bit not written");
    a_route_wr: assert property (s_wr(AR) |=> ##1
        (o_first_test_output_pin_oe_n == ($past(i_avs_writedata[7:4], 2) != SEL_DAC_REG)
        && o_second_test_output_pin_oe_n == ($past(i_avs_writedata[3:0], 2) != SEL_DAC_REG)))
        else $error("pin enable does not follow select code");
    a_dac1_rd: assert property (s_rd(A1) |=> o_avs_readdata == 32'(o_first_dac_code))
        else $error("first dac readback wrong");
    a_fd_rd: assert property (s_rd(AP) |=> o_avs_readdata == 32'({o_field_detector_powerdown, 4'h0}))
        else $error("detector control readback wrong");
endmodule

// ===== testbench/atr_regs_tb.sv
// self-checking bench for the analog test register set
module atr_regs_tb
    import atr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_sys_clk = 1'b0, i_nrst = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0;
    logic [15:0] i_avs_address = 16'h0;
    logic [31:0] i_avs_writedata = 32'h0, o_avs_readdata, rd;
    logic [3:0] i_avs_byteenable = 4'hF, i_adc_i_sample = 4'h0, i_adc_q_sample = 4'h0;
    logic o_avs_waitrequest, o_first_test_output_pin_oe_n, o_second_test_output_pin_oe_n, o_field_detector_powerdown;
    logic [1:0] o_avs_response;
    logic [5:0] o_first_dac_code, o_second_dac_code;
    int n_fail = 0, n_compared = 0;
    always #25 i_sys_clk = ~i_sys_clk;
    atr_regs i_atr_regs (
        .i_sys_clk                     (i_sys_clk),
        .i_nrst                        (i_nrst),
        .i_avs_address                 (i_avs_address),
        .i_avs_read                    (i_avs_read),
        .i_avs_write                   (i_avs_write),
        .i_avs_writedata               (i_avs_writedata),
        .i_avs_byteenable              (i_avs_byteenable),
        .o_avs_readdata                (o_avs_readdata),
        .o_avs_waitrequest             (o_avs_waitrequest),
        .o_avs_response                (o_avs_response),
        .i_adc_i_sample                (i_adc_i_sample),
        .i_adc_q_sample                (i_adc_q_sample),
        .o_first_dac_code              (o_first_dac_code),
        .o_second_dac_code             (o_second_dac_code),
        .o_first_test_output_pin_oe_n  (o_first_test_output_pin_oe_n),
        .o_second_test_output_pin_oe_n (o_second_test_output_pin_oe_n),
        .o_field_detector_powerdown    (o_field_detector_powerdown)
    );
    // one bus access; waits on waitrequest, then idles one edge so strobes never re-rise in the same step
    task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d, input logic [3:0] be);
        int n;
        n = 0;
        i_avs_write <= w;
        i_avs_read <= !w;
        i_avs_address <= {idx[13:0], 2'b00};
        i_avs_writedata <= 32'(d);
        i_avs_byteenable <= be;
        do begin @(posedge i_sys_clk); n++; end while (o_avs_waitrequest !== 1'b0 && n < 20);
        if (o_avs_waitrequest !== 1'b0) n_fail++;
        rd = o_avs_readdata;
        i_avs_write <= 1'b0;
        i_avs_read <= 1'b0;
        @(posedge i_sys_clk);
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wrap_up;
        if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // power-down set and cleared; software keeps reserved bits zero
    task automatic t_pd;
        cmp("pd reset", 32'h0, 32'(o_field_detector_powerdown));
        bus(1'b1, IDX_FIELD_DET, 8'h10, 4'h1);
        cmp("pd on", 32'h1, 32'(o_field_detector_powerdown));
        bus(1'b0, IDX_FIELD_DET, 8'h00, 4'hF);
        cmp("pd read", 32'h10, rd);
        cmp("response", 32'h0, 32'(o_avs_response));
        bus(1'b1, IDX_FIELD_DET, 8'h00, 4'h1);
        cmp("pd off", 32'h0, 32'(o_field_detector_powerdown));
    endtask
    // upper bits written as ones must read zero; masked and unmapped writes leave values alone
    task automatic t_dac;
        bus(1'b1, IDX_DAC_ONE, 8'hFF, 4'h1);
        bus(1'b1, IDX_DAC_TWO, 8'hEA, 4'h1);
        bus(1'b1, IDX_DAC_TWO, 8'h15, 4'hE);
        bus(1'b1, 16'h6331, 8'h07, 4'h1);
        cmp("dac1 out", 32'h3F, 32'(o_first_dac_code));
        cmp("dac2 out", 32'h2A, 32'(o_second_dac_code));
        bus(1'b0, IDX_DAC_ONE, 8'h00, 4'hF);
        cmp("dac1 read", 32'h3F, rd);
        bus(1'b0, IDX_DAC_TWO, 8'h00, 4'hF);
        cmp("dac2 read", 32'h2A, rd);
        bus(1'b0, 16'h6331, 8'h00, 4'hF);
        cmp("unmapped", 32'h0, rd);
    endtask
    // all four pairings of codes zero and one, ending on an unmodelled code that must float both pins
    task automatic t_route;
        logic [7:0] c [5] = '{8'h10, 8'h01, 8'h11, 8'h00, 8'h22};
        foreach (c[k]) begin
            bus(1'b1, IDX_ROUTE, c[k], 4'h1);
            cmp("pin oe", 32'({c[k][7:4] != SEL_DAC_REG, c[k][3:0] != SEL_DAC_REG}),
                32'({o_first_test_output_pin_oe_n, o_second_test_output_pin_oe_n}));
        end
    endtask
    // live samples must pass the synchroniser before the read
    task automatic t_adc;
        logic [7:0] s [3] = '{8'hA5, 8'h3C, 8'hF0};
        foreach (s[k]) begin
            i_adc_i_sample <= s[k][7:4];
            i_adc_q_sample <= s[k][3:0];
            repeat (6) @(posedge i_sys_clk);
            bus(1'b0, IDX_ADC_OBSERVE, 8'h00, 4'hF);
            cmp("adc obs", 32'(s[k]), rd);
        end
    endtask
    initial begin
        repeat (8) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        @(posedge i_sys_clk);
        t_pd;
        t_dac;
        t_route;
        t_adc;
        wrap_up;
    end
    // the tests need about 81 cycles; this cuts a hang short at 4000
    initial begin
        #200000;
        n_fail++;
        wrap_up;
    end
endmodule
bind atr_regs atr_regs_chk i_atr_regs_chk (
    .i_sys_clk                     (i_sys_clk),
    .i_nrst                        (i_nrst),
    .i_avs_read                    (i_avs_read),
    .i_avs_write                   (i_avs_write),
    .o_avs_waitrequest             (o_avs_waitrequest),
    .o_field_detector_powerdown    (o_field_detector_powerdown),
    .o_first_test_output_pin_oe_n  (o_first_test_output_pin_oe_n),
    .o_second_test_output_pin_oe_n (o_second_test_output_pin_oe_n),
    .i_avs_address                 (i_avs_address),
    .i_avs_writedata               (i_avs_writedata),
    .o_avs_readdata                (o_avs_readdata),
    .i_avs_byteenable              (i_avs_byteenable),
    .o_first_dac_code              (o_first_dac_code),
    .o_second_dac_code             (o_second_dac_code)
);
